// >>> core/ppm_pin_mux.sv
// Peripheral pin multiplexer with precedence, DMA edge triggers and sleep interrupt gating
// Behaviour
// - Port interrupts blocked unless sleep mode 00
// - Port0 bit1 rising edge fires first trigger
// - Port1 bit3 falling edge fires second trigger
// - Triggers only from input pins with function select 0; ADC enable not checked
// - Function select 1 gives pin to peripheral
// - Location bit picks each serial unit's pins
// - Serial A pins at port0/port1 bits 5:2
// - Serial B pins at port0 5:2, port1 7:4
// - Timer channel pins per location bit
// - ADC inputs on port0; 7,6 absent small
// - Port0 priority 00 favours serial A
// - Port0 priority 01 favours serial B
// - Serial A UART without flow frees port0 5,4, port1 3,2
// - Serial B UART without flow frees port0 3,2, port1 5,4
// - Port1 high,low,second bits 0 favour serial A
// - Freed serial A pins go to others
// - Port1 high,second bits 10 favour serial B
`timescale 1ns/1ps
module ppm_pin_mux
    import ppm_pkg::*;
#(
    parameter bit SMALL_PACKAGE = 1'b0
) (
    input  wire logic                 sys_clk,
    input  wire logic                 rst_b,
    input  wire ppm_cfg_s             cfg,
    input  wire logic [2:0]           port_irq_raw,
    input  wire logic [7:0]           port0_pin_in,
    input  wire logic [7:0]           port1_pin_in,
    output ppm_owner_e [7:0]          port0_owner,
    output ppm_owner_e [7:0]          port1_owner,
    output logic [7:0]                port0_gpio_oe,
    output logic [7:0]                port1_gpio_oe,
    output logic [7:0]                adc_input_connect,
    output logic [2:0]                port_irq,
    output logic                      gpio_dma_trigger_first,
    output logic                      gpio_dma_trigger_second
);

    // Walks a precedence order and returns the first candidate that wants the pin
    function automatic ppm_owner_e ppm_pick(input logic [3:0] req, input logic [7:0] order);
        ppm_owner_e win;
        logic [1:0] idx;
        win = PPM_OWN_NONE;
        for (int k = 3; k >= 0; k--) begin
            idx = order[2*k +: 2];
            if (req[idx] && win == PPM_OWN_NONE) begin
                win = ppm_owner_e'(3'(idx) + 3'h1);
            end
        end
        return win;
    endfunction

    // Pin requests of each peripheral
    logic [7:0] p0_req_a;
    logic [7:0] p0_req_b;
    logic [7:0] p0_req_ta;
    logic [7:0] p1_req_a;
    logic [7:0] p1_req_b;
    logic [7:0] p1_req_ta;
    logic [7:0] p1_req_tb;
    logic [7:0] p0_order;
    logic [7:0] p1_order;
    logic [7:0] absent;

    always_comb begin
        logic a_free;
        logic b_free;
        a_free = cfg.serial_a_uart && !cfg.serial_a_flow_ctrl;
        b_free = cfg.serial_b_uart && !cfg.serial_b_flow_ctrl;
        p0_req_a  = 8'h00;
        p0_req_b  = 8'h00;
        p0_req_ta = 8'h00;
        p1_req_a  = 8'h00;
        p1_req_b  = 8'h00;
        p1_req_ta = 8'h00;
        p1_req_tb = 8'h00;
        if (!cfg.serial_a_location_bit) begin
            p0_req_a = PPM_SER_A_LOC1_PINS & ~(a_free ? PPM_SER_A_LOC1_FLOW : 8'h00);
        end else begin
            p1_req_a = PPM_SER_A_LOC2_PINS & ~(a_free ? PPM_SER_A_LOC2_FLOW : 8'h00);
        end
        if (!cfg.serial_b_location_bit) begin
            p0_req_b = PPM_SER_B_LOC1_PINS & ~(b_free ? PPM_SER_B_LOC1_FLOW : 8'h00);
        end else begin
            p1_req_b = PPM_SER_B_LOC2_PINS & ~(b_free ? PPM_SER_B_LOC2_FLOW : 8'h00);
        end
        if (!cfg.timer_a_location_bit) begin
            p0_req_ta = PPM_TMR_A_LOC1_PINS;
        end else begin
            p1_req_ta = PPM_TMR_A_LOC2_PINS;
        end
        p1_req_tb = cfg.timer_b_location_bit ? PPM_TMR_B_LOC2_PINS : PPM_TMR_B_LOC1_PINS;
    end

    always_comb begin
        case (cfg.port0_priority_field)
            PPM_P0PRI_SER_A:      p0_order = PPM_ORD_A_B_TA_TB;
            PPM_P0PRI_SER_B:      p0_order = PPM_ORD_B_A_TA_TB;
            PPM_P0PRI_TMR_OVER_B: p0_order = PPM_ORD_TA_B_A_TB;
            PPM_P0PRI_TMR_OVER_A: p0_order = PPM_ORD_TA_A_B_TB;
            default:              p0_order = PPM_ORD_A_B_TA_TB;
        endcase
        // Unresolved port 1 combinations fall to this fixed order
        if (cfg.port1_priority[PPM_P1PRI_HIGH] && !cfg.port1_priority[PPM_P1PRI_SECOND]) begin
            p1_order = PPM_ORD_B_A_TA_TB;
        end else if (cfg.port1_priority[PPM_P1PRI_LOW] && !cfg.port1_priority[PPM_P1PRI_THIRD]) begin
            p1_order = PPM_ORD_TA_A_B_TB;
        end else if (cfg.port1_priority[PPM_P1PRI_SECOND]) begin
            // Timer B leads over all, then serial A ahead of serial B and timer A
            p1_order = PPM_ORD_TB_A_B_TA;
        end else begin
            p1_order = PPM_ORD_A_B_TA_TB;
        end
        absent = SMALL_PACKAGE ? PPM_SMALL_PKG_ABSENT : 8'h00;
    end

    // Pin ownership and GPIO drive
    ppm_owner_e [7:0] next_port0_owner;
    ppm_owner_e [7:0] next_port1_owner;
    logic [7:0]       next_port0_gpio_oe;
    logic [7:0]       next_port1_gpio_oe;
    logic [7:0]       next_adc_input_connect;

    always_comb begin
        for (int i = 0; i < PPM_PINS; i++) begin
            if (absent[i]) begin
                next_port0_owner[i] = PPM_OWN_NONE;
            end else if (cfg.adc_input_enable[i]) begin
                next_port0_owner[i] = PPM_OWN_ADC;
            end else if (cfg.port0_function_select[i]) begin
                next_port0_owner[i] = ppm_pick({1'b0, p0_req_ta[i], p0_req_b[i], p0_req_a[i]},
                                               p0_order);
            end else begin
                next_port0_owner[i] = PPM_OWN_GPIO;
            end
            if (cfg.port1_function_select[i]) begin
                next_port1_owner[i] = ppm_pick({p1_req_tb[i], p1_req_ta[i], p1_req_b[i],
                                                p1_req_a[i]}, p1_order);
            end else begin
                next_port1_owner[i] = PPM_OWN_GPIO;
            end
            next_port0_gpio_oe[i] = (next_port0_owner[i] == PPM_OWN_GPIO) && cfg.port0_direction[i];
            next_port1_gpio_oe[i] = (next_port1_owner[i] == PPM_OWN_GPIO) && cfg.port1_direction[i];
        end
        next_adc_input_connect = cfg.adc_input_enable & ~absent;
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            port0_owner       <= '{default: PPM_OWN_GPIO};
            port1_owner       <= '{default: PPM_OWN_GPIO};
            port0_gpio_oe     <= 8'h00;
            port1_gpio_oe     <= 8'h00;
            adc_input_connect <= 8'h00;
        end else begin
            port0_owner       <= next_port0_owner;
            port1_owner       <= next_port1_owner;
            port0_gpio_oe     <= next_port0_gpio_oe;
            port1_gpio_oe     <= next_port1_gpio_oe;
            adc_input_connect <= next_adc_input_connect;
        end
    end

    // DMA edge triggers and interrupt gating
    logic [1:0] sync_meta;
    logic [1:0] sync_pin;
    logic [1:0] sync_last;
    logic [1:0] next_sync_meta;
    logic [1:0] next_sync_pin;
    logic [1:0] next_sync_last;
    logic       first_armed;
    logic       second_armed;
    logic       next_trigger_first;
    logic       next_trigger_second;
    logic [2:0] next_port_irq;

    always_comb begin
        next_sync_meta = {port1_pin_in[PPM_DMA_P1_BIT], port0_pin_in[PPM_DMA_P0_BIT]};
        next_sync_pin  = sync_meta;
        next_sync_last = sync_pin;
        first_armed  = !cfg.port0_function_select[PPM_DMA_P0_BIT]
                       && !cfg.port0_direction[PPM_DMA_P0_BIT];
        second_armed = !cfg.port1_function_select[PPM_DMA_P1_BIT]
                       && !cfg.port1_direction[PPM_DMA_P1_BIT];
        next_trigger_first  = first_armed && sync_pin[0] && !sync_last[0];
        next_trigger_second = second_armed && !sync_pin[1] && sync_last[1];
        // Sleeping blocks all ports; wake-up is left to the power controller
        next_port_irq = (cfg.sleep_mode == PPM_SLEEP_ACTIVE) ? port_irq_raw : 3'h0;
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            // Pins idle high on their pull-ups after reset; starting the detector low
            // would fake a rising edge on the first trigger pin
            sync_meta               <= '1;
            sync_pin                <= '1;
            sync_last               <= '1;
            gpio_dma_trigger_first  <= 1'b0;
            gpio_dma_trigger_second <= 1'b0;
            port_irq                <= 3'h0;
        end else begin
            sync_meta               <= next_sync_meta;
            sync_pin                <= next_sync_pin;
            sync_last               <= next_sync_last;
            gpio_dma_trigger_first  <= next_trigger_first;
            gpio_dma_trigger_second <= next_trigger_second;
            port_irq                <= next_port_irq;
        end
    end

    default clocking ppm_cb @(posedge sys_clk); endclocking
    default disable iff (!rst_b);

    sequence s_p0_bit1_rise;
        !port0_pin_in[PPM_DMA_P0_BIT] ##1 port0_pin_in[PPM_DMA_P0_BIT];
    endsequence

    sequence s_p1_bit3_fall;
        port1_pin_in[PPM_DMA_P1_BIT] ##1 !port1_pin_in[PPM_DMA_P1_BIT];
    endsequence

    a_sleep_irq_block: assert property (
        cfg.sleep_mode != PPM_SLEEP_ACTIVE |=> port_irq == 3'h0)
        else $error("port interrupt passed while asleep");

    a_dma_first_rise: assert property (
        (s_p0_bit1_rise ##1 port0_pin_in[PPM_DMA_P0_BIT] && first_armed
            ##1 first_armed [*2]) |-> gpio_dma_trigger_first)
        else $error("rising edge on port0 bit1 gave no trigger");

    a_dma_second_fall: assert property (
        (s_p1_bit3_fall ##1 !port1_pin_in[PPM_DMA_P1_BIT] && second_armed
            ##1 second_armed [*2]) |-> gpio_dma_trigger_second)
        else $error("falling edge on port1 bit3 gave no trigger");

    a_dma_gpio_only: assert property (
        gpio_dma_trigger_first |-> $past(first_armed) ##1 !gpio_dma_trigger_first)
        else $error("first trigger from a non-input pin or longer than one cycle");

    a_dma_second_once: assert property (
        gpio_dma_trigger_second |-> $past(second_armed) ##1 !gpio_dma_trigger_second)
        else $error("second trigger from a non-input pin or longer than one cycle");

    a_gpio_by_select: assert property (
        !cfg.port1_function_select[0] |=> port1_owner[0] == PPM_OWN_GPIO)
        else $error("unselected pin not left as general purpose");

    a_p0_pri_ser_a: assert property (
        cfg.port0_priority_field == PPM_P0PRI_SER_A && p0_req_a[2] && p0_req_b[2]
            && cfg.port0_function_select[2] && !cfg.adc_input_enable[2]
            |=> port0_owner[2] == PPM_OWN_SER_A)
        else $error("serial A lost port0 pin under priority 00");

    a_p0_pri_ser_b: assert property (
        cfg.port0_priority_field == PPM_P0PRI_SER_B && p0_req_a[5] && p0_req_b[5]
            && cfg.port0_function_select[5] && !cfg.adc_input_enable[5]
            |=> port0_owner[5] == PPM_OWN_SER_B)
        else $error("serial B lost port0 pin under priority 01");

    a_flow_release_a: assert property (
        cfg.serial_a_uart && !cfg.serial_a_flow_ctrl |-> p0_req_a[5:4] == 2'h0
            && p1_req_a[3:2] == 2'h0)
        else $error("serial A kept flow pins without flow control");

    a_flow_release_b: assert property (
        cfg.serial_b_uart && !cfg.serial_b_flow_ctrl |-> p0_req_b[3:2] == 2'h0)
        else $error("serial B kept flow pins without flow control");

    a_p1_pri_ser_b: assert property (
        cfg.port1_priority[PPM_P1PRI_HIGH] && !cfg.port1_priority[PPM_P1PRI_SECOND]
            && p1_req_b[6] && cfg.port1_function_select[6]
            |=> port1_owner[6] == PPM_OWN_SER_B)
        else $error("serial B lost port1 pin under its priority");

    // Pin 2 is also a serial pin, so this shows the ADC beating function select
    a_adc_override: assert property (
        cfg.adc_input_enable[2] |=> port0_owner[2] == PPM_OWN_ADC && adc_input_connect[2])
        else $error("ADC input not mapped onto its port0 pin");

    a_gpio_oe_dir: assert property (
        !cfg.port0_function_select[4] && !cfg.adc_input_enable[4]
            |=> port0_gpio_oe[4] == $past(cfg.port0_direction[4]))
        else $error("general purpose pin drive does not follow direction");

    a_p1_pri_ser_a: assert property (
        !cfg.port1_priority[PPM_P1PRI_HIGH] && !cfg.port1_priority[PPM_P1PRI_LOW]
            && p1_req_a[5] && cfg.port1_function_select[5]
            |=> port1_owner[5] == PPM_OWN_SER_A)
        else $error("serial A lost port1 pin under its priority");

    a_p1_freed_a: assert property (
        cfg.serial_a_uart && !cfg.serial_a_flow_ctrl && cfg.serial_a_location_bit
            && cfg.port1_function_select[3]
            |=> port1_owner[3] != PPM_OWN_SER_A)
        else $error("freed port1 flow pin still held by serial A");

endmodule

// >>> core/ppm_pkg.sv
// Constants, owner codes and configuration carrier for the peripheral pin multiplexer
package ppm_pkg;

    localparam int          PPM_PINS            = 8;
    localparam logic [1:0]  PPM_SLEEP_ACTIVE    = 2'h0;

    // Port 0 priority field codes
    localparam logic [1:0]  PPM_P0PRI_SER_A     = 2'h0;
    localparam logic [1:0]  PPM_P0PRI_SER_B     = 2'h1;
    localparam logic [1:0]  PPM_P0PRI_TMR_OVER_B = 2'h2;
    localparam logic [1:0]  PPM_P0PRI_TMR_OVER_A = 2'h3;

    // Port 1 priority bit positions inside the 4-bit field
    localparam int          PPM_P1PRI_HIGH      = 3;
    localparam int          PPM_P1PRI_SECOND    = 2;
    localparam int          PPM_P1PRI_THIRD     = 1;
    localparam int          PPM_P1PRI_LOW       = 0;

    // Pin masks per peripheral and location; FLOW masks are the RTS/CTS pins
    localparam logic [7:0]  PPM_SER_A_LOC1_PINS = 8'h3c;
    localparam logic [7:0]  PPM_SER_A_LOC1_FLOW = 8'h30;
    localparam logic [7:0]  PPM_SER_A_LOC2_PINS = 8'h3c;
    localparam logic [7:0]  PPM_SER_A_LOC2_FLOW = 8'h0c;
    localparam logic [7:0]  PPM_SER_B_LOC1_PINS = 8'h3c;
    localparam logic [7:0]  PPM_SER_B_LOC1_FLOW = 8'h0c;
    localparam logic [7:0]  PPM_SER_B_LOC2_PINS = 8'hf0;
    localparam logic [7:0]  PPM_SER_B_LOC2_FLOW = 8'h30;
    localparam logic [7:0]  PPM_TMR_A_LOC1_PINS = 8'h1c;
    localparam logic [7:0]  PPM_TMR_A_LOC2_PINS = 8'h07;
    localparam logic [7:0]  PPM_TMR_B_LOC1_PINS = 8'h18;
    localparam logic [7:0]  PPM_TMR_B_LOC2_PINS = 8'hc0;
    localparam logic [7:0]  PPM_SMALL_PKG_ABSENT = 8'hc0;

    localparam int          PPM_DMA_P0_BIT      = 1;
    localparam int          PPM_DMA_P1_BIT      = 3;

    // Candidate indices and precedence orders, first choice in bits 7:6
    localparam logic [1:0]  PPM_IDX_SER_A       = 2'h0;
    localparam logic [1:0]  PPM_IDX_SER_B       = 2'h1;
    localparam logic [1:0]  PPM_IDX_TMR_A       = 2'h2;
    localparam logic [1:0]  PPM_IDX_TMR_B       = 2'h3;
    localparam logic [7:0]  PPM_ORD_A_B_TA_TB   = 8'h1b;
    localparam logic [7:0]  PPM_ORD_B_A_TA_TB   = 8'h4b;
    localparam logic [7:0]  PPM_ORD_TA_B_A_TB   = 8'h93;
    localparam logic [7:0]  PPM_ORD_TA_A_B_TB   = 8'h87;
    localparam logic [7:0]  PPM_ORD_TB_A_B_TA   = 8'hc6;

    typedef enum logic [2:0] {
        PPM_OWN_GPIO,
        PPM_OWN_SER_A,
        PPM_OWN_SER_B,
        PPM_OWN_TMR_A,
        PPM_OWN_TMR_B,
        PPM_OWN_ADC,
        PPM_OWN_NONE
    } ppm_owner_e;

    typedef struct packed {
        logic [1:0] sleep_mode;
        logic [7:0] port0_function_select;
        logic [7:0] port1_function_select;
        logic [7:0] port0_direction;
        logic [7:0] port1_direction;
        logic [7:0] adc_input_enable;
        logic       serial_a_location_bit;
        logic       serial_b_location_bit;
        logic       timer_a_location_bit;
        logic       timer_b_location_bit;
        logic       serial_a_uart;
        logic       serial_a_flow_ctrl;
        logic       serial_b_uart;
        logic       serial_b_flow_ctrl;
        logic [1:0] port0_priority_field;
        logic [3:0] port1_priority;
    } ppm_cfg_s;

endpackage

// >>> dv/ppm_pin_drv.sv
// Pin-side partner: drives the two DMA-capable pins and churns all others
`timescale 1ns/1ps
module ppm_pin_drv
    import ppm_pkg::*;
(
    input  wire logic  sys_clk,
    input  wire logic  p0_level,
    input  wire logic  p1_level,
    output logic [7:0] port0_pin_in,
    output logic [7:0] port1_pin_in
);
    logic [7:0] churn;
    initial begin
        churn = 8'h00;
        port0_pin_in = 8'h00;
        port1_pin_in = 8'h08;
    end
    // The unused-pin pattern changes every cycle, so a wrong pin decode cannot hide behind a stale level
    always @(negedge sys_clk) begin
        churn <= churn + 8'h5b;
        port0_pin_in <= (churn & 8'hfd) | {6'h00, p0_level, 1'b0};
        port1_pin_in <= (churn & 8'hf7) | {4'h0, p1_level, 3'h0};
    end
endmodule

// >>> dv/testbench.sv
// Self-checking bench for the peripheral pin multiplexer
`timescale 1ns/1ps
module testbench;
    import ppm_pkg::*;
    logic             sys_clk;
    logic             rst_b;
    ppm_cfg_s         cfg;
    logic [2:0]       port_irq_raw;
    logic             p0_level;
    logic             p1_level;
    logic [7:0]       port0_pin_in;
    logic [7:0]       port1_pin_in;
    ppm_owner_e [7:0] port0_owner;
    ppm_owner_e [7:0] port1_owner;
    logic [7:0]       port0_gpio_oe;
    logic [7:0]       port1_gpio_oe;
    logic [7:0]       adc_input_connect;
    logic [2:0]       port_irq;
    logic             gpio_dma_trigger_first;
    logic             gpio_dma_trigger_second;
    logic [7:0]       cnt_first = 8'h00;
    logic [7:0]       cnt_second = 8'h00;
    int               errors = 0;
    int               checks_done = 0;
    int               cycles = 0;

    ppm_pin_mux uut (
        .sys_clk                 (sys_clk),
        .rst_b                   (rst_b),
        .cfg                     (cfg),
        .port_irq_raw            (port_irq_raw),
        .port0_pin_in            (port0_pin_in),
        .port1_pin_in            (port1_pin_in),
        .port0_owner             (port0_owner),
        .port1_owner             (port1_owner),
        .port0_gpio_oe           (port0_gpio_oe),
        .port1_gpio_oe           (port1_gpio_oe),
        .adc_input_connect       (adc_input_connect),
        .port_irq                (port_irq),
        .gpio_dma_trigger_first  (gpio_dma_trigger_first),
        .gpio_dma_trigger_second (gpio_dma_trigger_second)
    );
    ppm_pin_drv pins (
        .sys_clk      (sys_clk),
        .p0_level     (p0_level),
        .p1_level     (p1_level),
        .port0_pin_in (port0_pin_in),
        .port1_pin_in (port1_pin_in)
    );

    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end
    // Counting high cycles also proves each pulse lasts exactly one cycle
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (gpio_dma_trigger_first === 1'b1) cnt_first <= cnt_first + 8'h01;
        if (gpio_dma_trigger_second === 1'b1) cnt_second <= cnt_second + 8'h01;
        if (cycles == 3000) begin
            errors++;
            end_of_test();
        end
    end

    task automatic end_of_test();
        $display("errors=%0d checks_done=%0d", errors, checks_done);
        if (errors == 0 && checks_done > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic check_own(input ppm_owner_e [7:0] got, input logic [7:0] mask,
                             input ppm_owner_e exp, input string msg);
        for (int i = 0; i < 8; i++) begin
            if (mask[i]) begin
                checks_done++;
                if (got[i] !== exp) begin
                    errors++;
                    $display("MISMATCH t=%0t %s bit %0d", $time, msg, i);
                end
            end
        end
    endtask
    task automatic check_bits(input logic [7:0] got, input logic [7:0] exp, input string msg);
        checks_done++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH t=%0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask

    task automatic t_reset();
        check_own(port0_owner, 8'hff, PPM_OWN_GPIO, "reset p0");
        check_own(port1_owner, 8'hff, PPM_OWN_GPIO, "reset p1");
        check_bits(port0_gpio_oe | port1_gpio_oe | adc_input_connect, 8'h00, "reset outs");
        check_bits({5'h00, port_irq}, 8'h00, "reset irq");
    endtask
    task automatic t_gpio();
        cfg = '0;
        cfg.port0_direction = 8'hf1;
        cfg.port1_direction = 8'h0f;
        cfg.port0_function_select = 8'h01;
        @(negedge sys_clk);
        check_own(port0_owner, 8'hfe, PPM_OWN_GPIO, "gpio p0");
        check_own(port0_owner, 8'h01, PPM_OWN_NONE, "idle periph");
        check_bits(port0_gpio_oe, 8'hf0, "oe p0");
        check_bits(port1_gpio_oe, 8'h0f, "oe p1");
    endtask
    task automatic t_irq();
        cfg = '0;
        for (int m = 0; m < 4; m++) begin
            cfg.sleep_mode = 2'(m);
            port_irq_raw = 3'(m + 5);
            @(negedge sys_clk);
            check_bits({5'h00, port_irq}, (m == 0) ? 8'h05 : 8'h00, "irq gate");
        end
    endtask
    task automatic t_port0();
        cfg = '0;
        cfg.port0_function_select = 8'h3c;
        @(negedge sys_clk);
        check_own(port0_owner, 8'h3c, PPM_OWN_SER_A, "p0 prio 00");
        cfg.port0_priority_field = 2'h1;
        @(negedge sys_clk);
        check_own(port0_owner, 8'h3c, PPM_OWN_SER_B, "p0 prio 01");
        cfg.port0_priority_field = 2'h0;
        cfg.serial_a_uart = 1'b1;
        @(negedge sys_clk);
        check_own(port0_owner, 8'h30, PPM_OWN_SER_B, "a freed");
        check_own(port0_owner, 8'h0c, PPM_OWN_SER_A, "a kept");
        cfg.serial_a_uart = 1'b0;
        cfg.serial_b_uart = 1'b1;
        cfg.port0_priority_field = 2'h1;
        @(negedge sys_clk);
        check_own(port0_owner, 8'h0c, PPM_OWN_SER_A, "b freed");
        check_own(port0_owner, 8'h30, PPM_OWN_SER_B, "b kept");
        cfg.serial_a_location_bit = 1'b1;
        cfg.port0_function_select = 8'h1c;
        cfg.port0_priority_field = 2'h2;
        @(negedge sys_clk);
        check_own(port0_owner, 8'h1c, PPM_OWN_TMR_A, "timer a loc1");
    endtask
    task automatic t_port1();
        cfg = '0;
        cfg.serial_a_location_bit = 1'b1;
        cfg.serial_b_location_bit = 1'b1;
        cfg.timer_a_location_bit = 1'b1;
        cfg.port1_function_select = 8'hff;
        @(negedge sys_clk);
        check_own(port1_owner, 8'hc0, PPM_OWN_SER_B, "p1 a-first b");
        check_own(port1_owner, 8'h3c, PPM_OWN_SER_A, "p1 a-first a");
        check_own(port1_owner, 8'h03, PPM_OWN_TMR_A, "p1 a-first ta");
        cfg.serial_a_uart = 1'b1;
        @(negedge sys_clk);
        check_own(port1_owner, 8'hc0, PPM_OWN_SER_B, "p1 freed b");
        check_own(port1_owner, 8'h30, PPM_OWN_SER_A, "p1 freed a");
        check_own(port1_owner, 8'h08, PPM_OWN_TMR_B, "p1 freed tb");
        check_own(port1_owner, 8'h07, PPM_OWN_TMR_A, "p1 freed ta");
        cfg.serial_a_uart = 1'b0;
        cfg.port1_priority = 4'h8;
        @(negedge sys_clk);
        check_own(port1_owner, 8'hf0, PPM_OWN_SER_B, "p1 b-first b");
        check_own(port1_owner, 8'h0c, PPM_OWN_SER_A, "p1 b-first a");
        cfg.timer_b_location_bit = 1'b1;
        cfg.port1_priority = 4'h4;
        @(negedge sys_clk);
        check_own(port1_owner, 8'hc0, PPM_OWN_TMR_B, "timer b loc2");
        check_own(port1_owner, 8'h3c, PPM_OWN_SER_A, "tb-first a");
    endtask
    task automatic t_adc();
        cfg = '0;
        cfg.adc_input_enable = 8'ha5;
        cfg.port0_function_select = 8'h3c;
        @(negedge sys_clk);
        check_bits(adc_input_connect, 8'ha5, "adc connect");
        check_own(port0_owner, 8'ha5, PPM_OWN_ADC, "adc owner");
        check_own(port0_owner, 8'h18, PPM_OWN_SER_A, "adc spare");
    endtask
    task automatic dma_step(input logic [7:0] s, input logic [7:0] d, input logic l0,
                            input logic l1, input logic [7:0] e1, input logic [7:0] e2);
        logic [7:0] b1;
        logic [7:0] b2;
        b1 = cnt_first;
        b2 = cnt_second;
        cfg = '0;
        cfg.port0_function_select = s;
        cfg.port1_function_select = s;
        cfg.port0_direction = d;
        cfg.port1_direction = d;
        p0_level <= l0;
        p1_level <= l1;
        repeat (8) @(negedge sys_clk);
        check_bits(cnt_first - b1, e1, "first trigger");
        check_bits(cnt_second - b2, e2, "second trigger");
    endtask
    task automatic t_dma();
        dma_step(8'h00, 8'h00, 1'b1, 1'b0, 8'h01, 8'h01);
        dma_step(8'h00, 8'h00, 1'b0, 1'b1, 8'h00, 8'h00);
        dma_step(8'h0a, 8'h00, 1'b1, 1'b0, 8'h00, 8'h00);
        dma_step(8'h00, 8'h00, 1'b0, 1'b1, 8'h00, 8'h00);
        dma_step(8'h00, 8'h0a, 1'b1, 1'b0, 8'h00, 8'h00);
    endtask

    initial begin
        rst_b = 1'b0;
        cfg = '0;
        port_irq_raw = 3'h0;
        p0_level = 1'b0;
        p1_level = 1'b1;
        repeat (10) @(negedge sys_clk);
        t_reset();
        rst_b = 1'b1;
        repeat (3) @(negedge sys_clk);
        t_gpio();
        t_irq();
        t_port0();
        t_port1();
        t_adc();
        t_dma();
        end_of_test();
    end
endmodule
